/* File: include/timer8_pkg.sv */
package timer8_pkg;
   // ==========================================
   // Register offsets (byte addresses on the plain register port)
   localparam logic [3:0] ADDR_CONTROL = 4'h0;  // Control: clock select, mode, action, force
   localparam logic [3:0] ADDR_COUNT   = 4'h1;  // Count value
   localparam logic [3:0] ADDR_COMPARE = 4'h2;  // Compare value (buffer or active)
   localparam logic [3:0] ADDR_FLAGS   = 4'h3;  // Flag register, write one to clear
   localparam logic [3:0] ADDR_MASK    = 4'h4;  // Interrupt mask register
   localparam logic [3:0] ADDR_ACTIVE  = 4'h5;  // Active compare value, read only

   // ==========================================
   // Control register fields
   localparam int CS_LSB    = 0;   // Clock select field, 3 bits
   localparam int WGM_LSB   = 3;   // Waveform mode field, 2 bits
   localparam int COM_LSB   = 5;   // Output action field, 2 bits
   localparam int FORCE_BIT = 7;   // Force match strobe, reads as zero

   // Flag and mask fields
   localparam int OVF_BIT   = 0;   // Overflow flag
   localparam int MATCH_BIT = 1;   // Compare match flag

   // ==========================================
   // Clock select codes
   localparam logic [2:0] CS_STOP  = 3'h0;
   localparam logic [2:0] CS_DIV1  = 3'h1;
   localparam logic [2:0] CS_DIV8  = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256  = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // Waveform modes
   localparam logic [1:0] WGM_NORMAL = 2'h0;
   localparam logic [1:0] WGM_PC_PWM = 2'h1;
   localparam logic [1:0] WGM_CTC    = 2'h2;
   localparam logic [1:0] WGM_FAST   = 2'h3;

   // Count limits
   localparam logic [7:0] BOTTOM_VAL = 8'h00;
   localparam logic [7:0] MAX_VAL    = 8'hff;

   // Prescaler width (ten bits covers a divide by 1024)
   localparam int PRE_W = 10;
endpackage

/* File: hdl/timer8_single_compare_core.sv */
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
module timer8_single_compare_core (
   input  wire logic       clock,          // 20 MHz system clock
   input  wire logic       srst,           // Synchronous reset, active high
   input  wire logic [3:0] addr,           // Register address
   input  wire logic [7:0] wdata,          // Write data
   input  wire logic       wr,             // Write strobe
   input  wire logic       rd,             // Read strobe
   output logic      [7:0] rdata,          // Read data, cycle after rd
   input  wire logic       ext_count_pin,  // External count pin
   input  wire logic       global_irq_en,  // Global enable from cpu_status_reg
   input  wire logic       overflow_ack,   // Overflow interrupt executed
   input  wire logic       match_ack,      // Compare interrupt executed
   input  wire logic       port_value,     // General port output value
   input  wire logic       port_dir,       // Port direction bit
   output logic            overflow_irq,   // Overflow interrupt request
   output logic            compare_irq,    // Compare interrupt request
   output logic            bottom_ind,     // Counter at bottom
   output logic            max_ind,        // Counter at max
   output logic            pin_out,        // Wave pin level
   output logic            pin_oe          // Wave pin output enable
);

   // ==========================================
   // State
   typedef enum logic [1:0] {
      DIR_UP   = 2'b00,  // Counting up
      DIR_DOWN = 2'b01   // Counting down (phase correct only)
   } dir_e;

   typedef struct packed {
      logic [2:0]                      clock_select_field;
      logic [1:0]                      waveform_mode_field;
      logic [1:0]                      output_action_field;
      logic [7:0]                      count_value_reg;
      logic [7:0]                      compare_value_reg;  // Active compare
      logic [7:0]                      compare_buffer;     // Double buffer
      logic [1:0]                      irq_flag_reg;
      logic [1:0]                      irq_mask_reg;
      logic                            wave_output;
      dir_e                            dir;
      logic                            block_match;        // Match blocked next tick
      logic                            match_pending;      // Match seen, flag at next tick
      logic [timer8_pkg::PRE_W-1:0]    prescale;
      logic                            pin_sync1;
      logic                            pin_sync2;
      logic                            pin_prev;
      logic [7:0]                      rdata;
   } state_s;

   state_s st;        // Registered state
   state_s next_st;   // Next state

   // ==========================================
   // Combinational helpers
   logic       pwm_mode;    // Either PWM mode active
   logic       tick;        // Timer tick enable
   logic [7:0] top_val;     // Top of the count sequence
   logic       match_now;   // Comparator equal
   logic       wave_match;  // Match applied to waveform
   logic       force_now;   // Force strobe this cycle
   logic       cnt_write;   // Host writes count this cycle
   logic       ovf_event;   // Overflow flag set this cycle

   // Mode decode
   always_comb begin
      pwm_mode = (st.waveform_mode_field == timer8_pkg::WGM_PC_PWM) ||
                 (st.waveform_mode_field == timer8_pkg::WGM_FAST);
      // Top is compare only in clear-on-match mode
      top_val  = (st.waveform_mode_field == timer8_pkg::WGM_CTC) ?
                 st.compare_value_reg : timer8_pkg::MAX_VAL;
      match_now = (st.count_value_reg == st.compare_value_reg);
      cnt_write = wr && (addr == timer8_pkg::ADDR_COUNT);
      force_now = wr && (addr == timer8_pkg::ADDR_CONTROL) &&
                  wdata[timer8_pkg::FORCE_BIT] && !pwm_mode;
      // Overflow event per mode; phase correct flags at the bottom turn
      ovf_event = tick && ((st.waveform_mode_field == timer8_pkg::WGM_PC_PWM) ?
                  (st.dir == DIR_DOWN && st.count_value_reg == timer8_pkg::BOTTOM_VAL) :
                  (st.count_value_reg == timer8_pkg::MAX_VAL));
   end

   // Tick select: prescaler taps or synchronised pin edges
   always_comb begin
      unique case (st.clock_select_field)
         timer8_pkg::CS_STOP:     tick = 1'b0;
         timer8_pkg::CS_DIV1:     tick = 1'b1;
         timer8_pkg::CS_DIV8:     tick = (st.prescale[2:0] == 3'h7);
         timer8_pkg::CS_DIV64:    tick = (st.prescale[5:0] == 6'h3f);
         timer8_pkg::CS_DIV256:   tick = (st.prescale[7:0] == 8'hff);
         timer8_pkg::CS_DIV1024:  tick = (st.prescale == 10'h3ff);
         // Edges come from the second sync stage only, never the first
         timer8_pkg::CS_EXT_FALL: tick = st.pin_prev && !st.pin_sync2;
         timer8_pkg::CS_EXT_RISE: tick = !st.pin_prev && st.pin_sync2;
      endcase
   end

   // Match as the waveform sees it: on a tick, unless blocked by a count write
   assign wave_match = tick && st.match_pending && !st.block_match;

   // ==========================================
   // Next state
   always_comb begin
      next_st = st;
      next_st.rdata = 8'h00;
      // Prescaler runs free; a shared divider, so phase is not reset per select
      // Limitation: the first divided tick after a select change may come early
      next_st.prescale = st.prescale + 10'h001;
      // Two-stage synchroniser then edge history
      next_st.pin_sync1 = ext_count_pin;
      next_st.pin_sync2 = st.pin_sync1;
      next_st.pin_prev  = st.pin_sync2;

      // Comparator result latched; flag follows on the next tick.
      // A count write blocks the match seen at the first tick after it,
      // so a counter loaded equal to the compare raises no flag at start.
      if (tick) begin
         next_st.match_pending = match_now && !st.block_match;
         next_st.block_match   = 1'b0;
      end

      // Count sequence on tick
      if (tick) begin
         unique case (st.waveform_mode_field)
            timer8_pkg::WGM_NORMAL, timer8_pkg::WGM_FAST: begin
               next_st.count_value_reg = st.count_value_reg + 8'h01;
               if (st.count_value_reg == timer8_pkg::MAX_VAL) begin
                  next_st.irq_flag_reg[timer8_pkg::OVF_BIT] = 1'b1;
               end
            end
            timer8_pkg::WGM_CTC: begin
               if (st.count_value_reg == top_val) begin
                  next_st.count_value_reg = timer8_pkg::BOTTOM_VAL;
               end else begin
                  next_st.count_value_reg = st.count_value_reg + 8'h01;
               end
               if (st.count_value_reg == timer8_pkg::MAX_VAL) begin
                  next_st.irq_flag_reg[timer8_pkg::OVF_BIT] = 1'b1;
               end
            end
            timer8_pkg::WGM_PC_PWM: begin
               // Dual slope: turn at max, turn at bottom and flag overflow
               if (st.dir == DIR_UP) begin
                  if (st.count_value_reg == top_val) begin
                     next_st.dir = DIR_DOWN;
                     next_st.count_value_reg = st.count_value_reg - 8'h01;
                  end else begin
                     next_st.count_value_reg = st.count_value_reg + 8'h01;
                  end
               end else begin
                  if (st.count_value_reg == timer8_pkg::BOTTOM_VAL) begin
                     next_st.dir = DIR_UP;
                     next_st.count_value_reg = st.count_value_reg + 8'h01;
                     next_st.irq_flag_reg[timer8_pkg::OVF_BIT] = 1'b1;
                  end else begin
                     next_st.count_value_reg = st.count_value_reg - 8'h01;
                  end
               end
            end
         endcase
         // Buffer copy at top or bottom in PWM modes
         if (pwm_mode && ((st.count_value_reg == top_val) ||
                          (st.count_value_reg == timer8_pkg::BOTTOM_VAL))) begin
            next_st.compare_value_reg = st.compare_buffer;
         end
      end
      if (st.waveform_mode_field != timer8_pkg::WGM_PC_PWM) begin
         next_st.dir = DIR_UP;
      end

      // Waveform output; action read live, no buffering
      if (wave_match || force_now) begin
         unique case (st.output_action_field)
            2'h0: next_st.wave_output = st.wave_output;
            2'h1: next_st.wave_output = pwm_mode ? st.wave_output : !st.wave_output;
            2'h2: next_st.wave_output = pwm_mode &&
                                        (st.dir == DIR_DOWN) ? 1'b1 : 1'b0;
            2'h3: next_st.wave_output = pwm_mode &&
                                        (st.dir == DIR_DOWN) ? 1'b0 : 1'b1;
         endcase
      end else if (tick && st.waveform_mode_field == timer8_pkg::WGM_FAST &&
                   st.count_value_reg == timer8_pkg::MAX_VAL &&
                   st.output_action_field[1]) begin
         // Fast PWM restores the idle level when the count wraps to bottom
         next_st.wave_output = !st.output_action_field[0];
      end

      // Match flag set from hardware; only real matches, never force
      if (wave_match) begin
         next_st.irq_flag_reg[timer8_pkg::MATCH_BIT] = 1'b1;
      end

      // Interrupt acknowledge; a new set in the same cycle wins
      if (match_ack && !wave_match) begin
         next_st.irq_flag_reg[timer8_pkg::MATCH_BIT] = 1'b0;
      end
      // One overflow event feeds the set and both clears, so set wins in every mode
      if (overflow_ack && !ovf_event) begin
         next_st.irq_flag_reg[timer8_pkg::OVF_BIT] = 1'b0;
      end

      // Host writes
      if (wr) begin
         unique case (addr)
            timer8_pkg::ADDR_CONTROL: begin
               // Mode change leaves wave_output alone
               next_st.clock_select_field  = wdata[timer8_pkg::CS_LSB +: 3];
               next_st.waveform_mode_field = wdata[timer8_pkg::WGM_LSB +: 2];
               next_st.output_action_field = wdata[timer8_pkg::COM_LSB +: 2];
            end
            timer8_pkg::ADDR_COUNT: begin
               next_st.count_value_reg = wdata;
               next_st.block_match     = 1'b1;
               next_st.match_pending   = 1'b0;
            end
            timer8_pkg::ADDR_COMPARE: begin
               if (pwm_mode) begin
                  next_st.compare_buffer = wdata;
               end else begin
                  next_st.compare_value_reg = wdata;
                  next_st.compare_buffer    = wdata;
               end
            end
            timer8_pkg::ADDR_FLAGS: begin
               // Write one clears, but a same-cycle hardware set wins
               if (wdata[timer8_pkg::MATCH_BIT] && !wave_match) begin
                  next_st.irq_flag_reg[timer8_pkg::MATCH_BIT] = 1'b0;
               end
               if (wdata[timer8_pkg::OVF_BIT] && !ovf_event) begin
                  next_st.irq_flag_reg[timer8_pkg::OVF_BIT] = 1'b0;
               end
            end
            timer8_pkg::ADDR_MASK: next_st.irq_mask_reg = wdata[1:0];
            default: ;
         endcase
      end

      // Host reads, data in the following cycle
      if (rd) begin
         unique case (addr)
            timer8_pkg::ADDR_CONTROL: next_st.rdata = {1'b0, st.output_action_field,
                                                       st.waveform_mode_field,
                                                       st.clock_select_field};
            timer8_pkg::ADDR_COUNT:   next_st.rdata = st.count_value_reg;
            timer8_pkg::ADDR_COMPARE: next_st.rdata = pwm_mode ? st.compare_buffer
                                                               : st.compare_value_reg;
            timer8_pkg::ADDR_FLAGS:   next_st.rdata = {6'h00, st.irq_flag_reg};
            timer8_pkg::ADDR_MASK:    next_st.rdata = {6'h00, st.irq_mask_reg};
            timer8_pkg::ADDR_ACTIVE:  next_st.rdata = st.compare_value_reg;
            default:                  next_st.rdata = 8'h00;
         endcase
      end
   end

   // ==========================================
   // State register
   // Synchronous reset clears all state, the waveform register included
   always_ff @(posedge clock) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================
   // Outputs
   assign rdata        = st.rdata;
   assign bottom_ind   = (st.count_value_reg == timer8_pkg::BOTTOM_VAL);
   assign max_ind      = (st.count_value_reg == timer8_pkg::MAX_VAL);
   assign compare_irq  = st.irq_flag_reg[timer8_pkg::MATCH_BIT] &&
                         st.irq_mask_reg[timer8_pkg::MATCH_BIT] && global_irq_en;
   assign overflow_irq = st.irq_flag_reg[timer8_pkg::OVF_BIT] &&
                         st.irq_mask_reg[timer8_pkg::OVF_BIT] && global_irq_en;
   // Pin source switch is independent of the waveform mode
   assign pin_out = (st.output_action_field != 2'h0) ? st.wave_output : port_value;
   assign pin_oe  = port_dir;

   // ==========================================
   // Checks
   sequence count_wr_s;
      cnt_write;
   endsequence

   count_write_a: assert property (@(posedge clock) disable iff (srst)
      count_wr_s |=> st.count_value_reg == $past(wdata))
      else $error("count write not stored");
   match_flag_a: assert property (@(posedge clock) disable iff (srst)
      (tick && st.match_pending && !st.block_match) |=> st.irq_flag_reg[1])
      else $error("match flag not set");
   block_match_a: assert property (@(posedge clock) disable iff (srst)
      count_wr_s |=> !wave_match)
      else $error("match not blocked after count write");
   flag_clear_a: assert property (@(posedge clock) disable iff (srst)
      (wr && addr == timer8_pkg::ADDR_FLAGS && wdata[1] && !wave_match)
      |=> !st.irq_flag_reg[1])
      else $error("flag not cleared by write one");
   irq_gate_a: assert property (@(posedge clock) disable iff (srst)
      compare_irq |-> st.irq_flag_reg[1] && st.irq_mask_reg[1] && global_irq_en)
      else $error("compare irq without cause");
   stop_hold_a: assert property (@(posedge clock) disable iff (srst)
      (st.clock_select_field == timer8_pkg::CS_STOP && !wr) |=>
      st.count_value_reg == $past(st.count_value_reg))
      else $error("counter moved while stopped");
   force_flag_a: assert property (@(posedge clock) disable iff (srst)
      (force_now && !wave_match && !st.irq_flag_reg[1] && !match_ack) |=>
      !st.irq_flag_reg[1])
      else $error("force set the match flag");
   pin_route_a: assert property (@(posedge clock) disable iff (srst)
      st.output_action_field != 2'h0 |-> pin_out == st.wave_output)
      else $error("pin not routed to waveform");
   buffer_hold_a: assert property (@(posedge clock) disable iff (srst)
      (pwm_mode && !tick && !wr) |=> st.compare_value_reg == $past(st.compare_value_reg))
      else $error("active compare changed outside top or bottom");

   // A blocked tick leaves no match behind for the flag;
   // otherwise a count loaded equal to the compare would still flag
   block_tick_a: assert property (@(posedge clock) disable iff (srst)
      (tick && st.block_match) |=> !st.match_pending)
      else $error("match kept after blocked tick");
   // Overflow event reaches the flag even beside an ack or a write one
   ovf_flag_a: assert property (@(posedge clock) disable iff (srst)
      ovf_event |=> st.irq_flag_reg[timer8_pkg::OVF_BIT])
      else $error("overflow flag not set");
   // Action zero keeps the waveform register on a match
   wave_keep_a: assert property (@(posedge clock) disable iff (srst)
      (wave_match && st.output_action_field == 2'h0) |=> $stable(st.wave_output))
      else $error("waveform moved with action zero");
   // Reset leaves the waveform register low
   wave_reset_a: assert property (@(posedge clock)
      srst |=> !st.wave_output)
      else $error("waveform not cleared by reset");
   // Clear on match wraps to bottom at the compare value
   clear_top_a: assert property (@(posedge clock) disable iff (srst)
      (tick && !cnt_write && st.waveform_mode_field == timer8_pkg::WGM_CTC &&
       st.count_value_reg == st.compare_value_reg) |=> bottom_ind)
      else $error("clear on match did not wrap");
   // Force never moves the counter
   force_count_a: assert property (@(posedge clock) disable iff (srst)
      (force_now && !tick) |=> $stable(st.count_value_reg))
      else $error("force moved the counter");
   // Control writes without match, force or tick keep the waveform register
   mode_keep_a: assert property (@(posedge clock) disable iff (srst)
      (wr && addr == timer8_pkg::ADDR_CONTROL && !wave_match && !force_now && !tick)
      |=> $stable(st.wave_output))
      else $error("waveform changed on mode write");
endmodule

/* File: tb/host_model.sv */
`timescale 1ns/10ps
// ==========================================
// Host side: register bus master and interrupt acknowledge
module host_model (
   input  wire logic       clock,         // System clock
   input  wire logic [7:0] rdata,         // Read data from the timer
   output logic      [3:0] addr,          // Register address
   output logic      [7:0] wdata,         // Write data
   output logic            wr,            // Write strobe
   output logic            rd,            // Read strobe
   output logic            match_ack,     // Compare interrupt executed
   output logic            overflow_ack   // Overflow interrupt executed
);
   // Bus idle at time zero
   initial begin
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'h0;
      rd = 1'h0;
      match_ack = 1'h0;
      overflow_ack = 1'h0;
   end
   // One-cycle write; data are scrambled once the strobe drops so nothing stale lingers
   task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge clock);
      wr    <= 1'h0;
      wdata <= ~d;
   endtask
   // One-cycle read; data are taken mid-cycle where they are settled
   task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd   <= 1'h1;
      @(posedge clock);
      rd   <= 1'h0;
      @(negedge clock);
      d = rdata;
   endtask
   // Interrupt executed: one-cycle acknowledge pulse
   task automatic ack(input logic is_match);
      @(posedge clock);
      if (is_match) match_ack <= 1'h1;
      else overflow_ack <= 1'h1;
      @(posedge clock);
      match_ack    <= 1'h0;
      overflow_ack <= 1'h0;
   endtask
endmodule

/* File: tb/timer8_single_compare_core_bench.sv */
`timescale 1ns/10ps
`define CHK(w, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("BAD %s expected %h seen %h", w, e, g); end end
// ==========================================
// Bench top
module timer8_single_compare_core_bench;
   localparam logic [3:0] cnt = timer8_pkg::ADDR_COUNT;   // Count register
   localparam logic [3:0] cmp = timer8_pkg::ADDR_COMPARE; // Compare register
   localparam logic [3:0] flg = timer8_pkg::ADDR_FLAGS;   // Flag register
   localparam logic [3:0] msk = timer8_pkg::ADDR_MASK;    // Mask register
   localparam logic [3:0] ctr = timer8_pkg::ADDR_CONTROL; // Control register
   logic       clock = 1'h0;           // 20 MHz clock
   logic       srst = 1'h1;            // Reset held from time zero
   logic       ext_count_pin = 1'h0;   // External count input
   logic       global_irq_en = 1'h0;   // Global enable
   logic       port_value = 1'h1;      // General port value
   logic       port_dir = 1'h0;        // Pin direction
   logic [3:0] addr;                   // Bus address
   logic [7:0] wdata, rdata, v;        // Bus data and last read
   logic       wr, rd, match_ack, overflow_ack;
   logic       overflow_irq, compare_irq, bottom_ind, max_ind, pin_out, pin_oe;
   int         fails = 0;              // Mismatches seen
   int         checks_done = 0;        // Comparisons made
   always #25 clock = ~clock;
   // ==========================================
   // Design and host
   timer8_single_compare_core i_dut (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .ext_count_pin(ext_count_pin),
      .global_irq_en(global_irq_en), .overflow_ack(overflow_ack), .match_ack(match_ack),
      .port_value(port_value), .port_dir(port_dir), .overflow_irq(overflow_irq),
      .compare_irq(compare_irq), .bottom_ind(bottom_ind), .max_ind(max_ind),
      .pin_out(pin_out), .pin_oe(pin_oe));
   host_model i_host (.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .match_ack(match_ack), .overflow_ack(overflow_ack));
   // ==========================================
   // Helpers
   function automatic logic [7:0] ctl(logic [2:0] cs, logic [1:0] m, logic [1:0] a, logic f);
      return {f, a, m, cs};
   endfunction
   task automatic wr_(input logic [3:0] a, input logic [7:0] d);
      i_host.write_reg(a, d);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string w);
      i_host.read_reg(a, v);
      `CHK(w, e, v)
   endtask
   // Bounded wait so a missing match cannot hang the run
   task automatic wait_irq;
      for (int i = 0; i < 600 && compare_irq !== 1'h1; i++) @(posedge clock);
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clock) ext_count_pin <= 1'h1;
         repeat (4) @(posedge clock);
         ext_count_pin <= 1'h0;
         repeat (4) @(posedge clock);
      end
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset;
      `CHK("bottom", 1'h1, bottom_ind)
      `CHK("max", 1'h0, max_ind)
      `CHK("pin", 1'h1, pin_out)
      `CHK("oe", 1'h0, pin_oe)
      wr_(ctr, ctl(timer8_pkg::CS_STOP, timer8_pkg::WGM_NORMAL, 2'h1, 1'h0));
      @(negedge clock) `CHK("wave", 1'h0, pin_out)
      rd_chk(cnt, 8'h00, "count");
      rd_chk(4'h9, 8'h00, "unmapped");
      wr_(cnt, 8'hff);
      @(negedge clock) `CHK("max", 1'h1, max_ind)
      rd_chk(cnt, 8'hff, "count");
      wr_(cmp, 8'h5a);
      rd_chk(timer8_pkg::ADDR_ACTIVE, 8'h5a, "active");
      rd_chk(cmp, 8'h5a, "compare");
      $display("done reset and registers");
   endtask
   task automatic t_match;
      @(posedge clock) global_irq_en <= 1'h1;
      wr_(cmp, 8'h10);
      wr_(cnt, 8'h00);
      wr_(flg, 8'h03);
      wr_(msk, 8'h02);
      wr_(ctr, ctl(timer8_pkg::CS_DIV1, timer8_pkg::WGM_NORMAL, 2'h0, 1'h0));
      wait_irq();
      wr_(ctr, 8'h00);
      @(negedge clock) `CHK("irq", 1'h1, compare_irq)
      wr_(msk, 8'h00);
      @(negedge clock) `CHK("irq", 1'h0, compare_irq)
      wr_(msk, 8'h02);
      @(posedge clock) global_irq_en <= 1'h0;
      @(negedge clock) `CHK("irq", 1'h0, compare_irq)
      @(posedge clock) global_irq_en <= 1'h1;
      wr_(flg, 8'h01);
      @(negedge clock) `CHK("irq", 1'h1, compare_irq)
      wr_(flg, 8'h02);
      @(negedge clock) `CHK("irq", 1'h0, compare_irq)
      wr_(ctr, ctl(timer8_pkg::CS_DIV1, timer8_pkg::WGM_NORMAL, 2'h0, 1'h0));
      wait_irq();
      wr_(ctr, 8'h00);
      i_host.ack(1'h1);
      @(negedge clock) `CHK("irq", 1'h0, compare_irq)
      wr_(msk, 8'h03);
      @(negedge clock) `CHK("ovf irq", 1'h1, overflow_irq)
      i_host.ack(1'h0);
      @(negedge clock) `CHK("ovf irq", 1'h0, overflow_irq)
      $display("done match and flags");
   endtask
   // Count write equal to compare must not raise the flag on the first tick
   task automatic t_block;
      wr_(flg, 8'h03);
      wr_(cmp, 8'h20);
      wr_(cnt, 8'h20);
      wr_(ctr, ctl(timer8_pkg::CS_DIV1, timer8_pkg::WGM_NORMAL, 2'h0, 1'h0));
      wr_(ctr, 8'h00);
      rd_chk(flg, 8'h00, "flags");
      $display("done match blocking");
   endtask
   task automatic t_force;
      logic [1:0] act [4] = '{2'h1, 2'h3, 2'h2, 2'h1};
      logic       exp [4] = '{1'h1, 1'h1, 1'h0, 1'h1};
      @(posedge clock) port_value <= 1'h0;
      for (int i = 0; i < 4; i++) begin
         // Action first; the strobe then applies the action already held
         wr_(ctr, ctl(timer8_pkg::CS_STOP, timer8_pkg::WGM_NORMAL, act[i], 1'h0));
         wr_(ctr, ctl(timer8_pkg::CS_STOP, timer8_pkg::WGM_NORMAL, act[i], 1'h1));
         @(negedge clock) `CHK("pin", exp[i], pin_out)
      end
      rd_chk(flg, 8'h00, "flags");
      @(posedge clock) port_dir <= 1'h1;
      @(negedge clock) `CHK("oe", 1'h1, pin_oe)
      wr_(ctr, ctl(timer8_pkg::CS_STOP, timer8_pkg::WGM_FAST, 2'h2, 1'h0));
      wr_(ctr, ctl(timer8_pkg::CS_STOP, timer8_pkg::WGM_FAST, 2'h2, 1'h1));
      @(negedge clock) `CHK("pin", 1'h1, pin_out)
      wr_(ctr, ctl(timer8_pkg::CS_STOP, timer8_pkg::WGM_FAST, 2'h0, 1'h0));
      @(negedge clock) `CHK("pin", 1'h0, pin_out)
      $display("done force and output");
   endtask
   task automatic t_buffer;
      wr_(cmp, 8'h33);
      rd_chk(timer8_pkg::ADDR_ACTIVE, 8'h20, "active");
      rd_chk(cmp, 8'h33, "buffer");
      wr_(ctr, ctl(timer8_pkg::CS_DIV1, timer8_pkg::WGM_FAST, 2'h0, 1'h0));
      repeat (300) @(posedge clock);
      wr_(ctr, ctl(timer8_pkg::CS_STOP, timer8_pkg::WGM_CTC, 2'h0, 1'h0));
      rd_chk(timer8_pkg::ADDR_ACTIVE, 8'h33, "active");
      wr_(cmp, 8'h05);
      wr_(cnt, 8'h00);
      wr_(flg, 8'h03);
      wr_(ctr, ctl(timer8_pkg::CS_DIV1, timer8_pkg::WGM_CTC, 2'h0, 1'h0));
      repeat (50) @(posedge clock);
      wr_(ctr, 8'h00);
      i_host.read_reg(cnt, v);
      `CHK("ctc top", 1'h1, v <= 8'h05)
      i_host.read_reg(flg, v);
      `CHK("ovf flag", 1'h0, v[timer8_pkg::OVF_BIT])
      $display("done buffering and top");
   endtask
   task automatic t_ext;
      wr_(cnt, 8'h00);
      wr_(ctr, ctl(timer8_pkg::CS_EXT_RISE, timer8_pkg::WGM_NORMAL, 2'h0, 1'h0));
      pulses(3);
      rd_chk(cnt, 8'h03, "ext count");
      wr_(ctr, 8'h00);
      pulses(2);
      rd_chk(cnt, 8'h03, "stopped");
      $display("done external count");
   endtask
   // ==========================================
   // Verdict
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog: the tests need under 3000 cycles
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge clock);
      srst <= 1'h0;
      @(negedge clock);
      t_reset();
      t_match();
      t_block();
      t_force();
      t_buffer();
      t_ext();
      finish_test();
   end
endmodule
